// ==== tcs_pkg.sv ====
// Package: register map, field positions and reset values of the timer channel status block
package tcs_pkg;
  // Register byte offsets
  localparam logic [7:0] TCS_OFF_CMP_B = 8'h00;
  localparam logic [7:0] TCS_OFF_CMP_C = 8'h04;
  localparam logic [7:0] TCS_OFF_STATUS = 8'h08;
  localparam logic [7:0] TCS_OFF_IRQ_EN = 8'h0c;
  localparam logic [7:0] TCS_OFF_IRQ_DIS = 8'h10;
  localparam logic [7:0] TCS_OFF_IRQ_MASK = 8'h14;
  // Event flag positions
  localparam int TCS_EV_OVF = 0;
  localparam int TCS_EV_LOVR = 1;
  localparam int TCS_EV_CPA = 2;
  localparam int TCS_EV_CPB = 3;
  localparam int TCS_EV_CPC = 4;
  localparam int TCS_EV_LDA = 5;
  localparam int TCS_EV_LDB = 6;
  localparam int TCS_EV_ETRG = 7;
  localparam int TCS_NUM_EV = 8;
  // Live level positions
  localparam int TCS_ST_CLK = 16;
  localparam int TCS_ST_MIRA = 17;
  localparam int TCS_ST_MIRB = 18;
  // Reset values
  localparam logic [15:0] TCS_RST_CMP = 16'h0000;
  localparam logic [7:0] TCS_RST_EV = 8'h00;
  localparam logic [7:0] TCS_RST_MASK = 8'h00;
endpackage : tcs_pkg

// ==== tcs_sync2.sv ====
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module tcs_sync2 (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } tcs_sync_st_t;
  tcs_sync_st_t st_q;
  tcs_sync_st_t st_d;

  // Shift stage
  always_comb begin
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end

  // State flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;
endmodule : tcs_sync2
`default_nettype wire

// ==== tcs_top.sv ====
// Timer channel status, compare B/C and interrupt mask registers on APB
// Operation
// (RULE_01) Compare B: read-only capture, writable waveform
// (RULE_02) Compare C: 16-bit read-write, live value
// (RULE_03) Overflow flag sticky until status read
// (RULE_04) Load overrun flag, capture mode only
// (RULE_05) Match A flag, waveform mode only
// (RULE_06) Match B flag, waveform mode only
// (RULE_07) Match C flag in both modes
// (RULE_08) Load A flag, capture mode only
// (RULE_09) Load B flag, capture mode only
// (RULE_10) External trigger flag sticky until read
// (RULE_11) Bit 16 shows counter clock live
// (RULE_12) Bit 17 mirrors line A level
// (RULE_13) Bit 18 mirrors line B level
// (RULE_14) Enable write sets mask bits written one
// (RULE_15) Disable write clears mask bits written one
// (RULE_16) Mask register read returns current mask
// (RULE_17) Interrupt when any flag and mask both
// (RULE_18) Status read clears only event flags
`timescale 1ns/1ps
`default_nettype none
module tcs_top
  import tcs_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter core side
  input wire logic wave_mode,
  input wire logic counter_clock_on,
  input wire logic ev_overflow,
  input wire logic ev_match_a,
  input wire logic ev_match_b,
  input wire logic ev_match_c,
  input wire logic ev_ext_trigger,
  input wire logic ev_load_a,
  input wire logic ev_load_b,
  input wire logic [15:0] capture_b_data,
  input wire logic read_capture_a,
  // Timer lines
  input wire logic timer_line_a_pin,
  input wire logic timer_line_b_pin,
  input wire logic timer_line_a_drv,
  input wire logic timer_line_b_drv,
  // Interrupt request
  output logic irq
);
  typedef struct packed {
    logic [15:0] cmp_b;
    logic [15:0] cmp_c;
    logic [7:0] flags;
    logic [7:0] mask;
    logic pend_a;
    logic pend_b;
    logic [31:0] rdata;
  } tcs_state_t;

  tcs_state_t st_q;
  tcs_state_t st_d;
  logic line_a_sync;
  logic line_b_sync;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] ev;
  logic [31:0] status_word;
  logic line_a_mirror;
  logic line_b_mirror;
  logic hit;
  logic rd_b;
  logic [15:0] b_wr_val;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  tcs_sync2 u_sync_a (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(timer_line_a_pin),
    .sync_out(line_a_sync)
  );
  tcs_sync2 u_sync_b (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(timer_line_b_pin),
    .sync_out(line_b_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign rd_b = rd && (paddr == TCS_OFF_CMP_B);
  assign hit = (paddr == TCS_OFF_CMP_B) || (paddr == TCS_OFF_CMP_C) ||
               (paddr == TCS_OFF_STATUS) || (paddr == TCS_OFF_IRQ_EN) ||
               (paddr == TCS_OFF_IRQ_DIS) || (paddr == TCS_OFF_IRQ_MASK);

  // Line mirrors: sampled pin in capture, driven level in waveform
  // (RULE_12) line A mirror
  assign line_a_mirror = wave_mode ? timer_line_a_drv : line_a_sync;
  // (RULE_13) line B mirror
  assign line_b_mirror = wave_mode ? timer_line_b_drv : line_b_sync;

  // Raw events gated by mode
  always_comb begin
    ev = '0;
    // (RULE_03) overflow event
    ev[TCS_EV_OVF] = ev_overflow;
    // (RULE_04) overrun on second unread load
    ev[TCS_EV_LOVR] = !wave_mode && ((ev_load_a && st_q.pend_a) ||
                                     (ev_load_b && st_q.pend_b));
    // (RULE_05) match A in waveform
    ev[TCS_EV_CPA] = wave_mode && ev_match_a;
    // (RULE_06) match B in waveform
    ev[TCS_EV_CPB] = wave_mode && ev_match_b;
    // (RULE_07) match C any mode
    ev[TCS_EV_CPC] = ev_match_c;
    // (RULE_08) load A in capture
    ev[TCS_EV_LDA] = !wave_mode && ev_load_a;
    // (RULE_09) load B in capture
    ev[TCS_EV_LDB] = !wave_mode && ev_load_b;
    // (RULE_10) external trigger event
    ev[TCS_EV_ETRG] = ev_ext_trigger;
  end

  // Status word assembly
  always_comb begin
    status_word = '0;
    status_word[TCS_NUM_EV-1:0] = st_q.flags;
    // (RULE_11) live clock state
    status_word[TCS_ST_CLK] = counter_clock_on;
    status_word[TCS_ST_MIRA] = line_a_mirror;
    status_word[TCS_ST_MIRB] = line_b_mirror;
  end

  // Byte-lane merge for compare writes
  function automatic logic [15:0] tcs_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : tcs_merge

  assign b_wr_val = tcs_merge(st_q.cmp_b, pwdata, pstrb);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    // Compare B: capture loads in capture mode, software in waveform
    // (RULE_01) compare B access
    if (!wave_mode && ev_load_b) begin
      st_d.cmp_b = capture_b_data;
    end else if (wave_mode && wr && paddr == TCS_OFF_CMP_B) begin
      st_d.cmp_b = b_wr_val;
    end
    // (RULE_02) compare C write
    if (wr && paddr == TCS_OFF_CMP_C) begin
      st_d.cmp_c = tcs_merge(st_q.cmp_c, pwdata, pstrb);
    end
    // Unread-load tracking; a new load wins over a read
    if (ev_load_a) begin
      st_d.pend_a = 1'b1;
    end else if (read_capture_a) begin
      st_d.pend_a = 1'b0;
    end
    if (ev_load_b) begin
      st_d.pend_b = 1'b1;
    end else if (rd_b) begin
      st_d.pend_b = 1'b0;
    end
    // (RULE_18) read clears flags, new event wins
    if (rd && paddr == TCS_OFF_STATUS) begin
      st_d.flags = ev;
    end else begin
      st_d.flags = st_q.flags | ev;
    end
    // (RULE_14) enable sets mask bits
    if (wr && paddr == TCS_OFF_IRQ_EN && pstrb[0]) begin
      st_d.mask = st_q.mask | pwdata[TCS_NUM_EV-1:0];
    end
    // (RULE_15) disable clears mask bits
    if (wr && paddr == TCS_OFF_IRQ_DIS && pstrb[0]) begin
      st_d.mask = st_q.mask & ~pwdata[TCS_NUM_EV-1:0];
    end
    // Read data capture in setup phase
    if (psel && !penable && !pwrite) begin
      case (paddr)
        // (RULE_01) compare B readback
        TCS_OFF_CMP_B: st_d.rdata = {16'h0000, st_q.cmp_b};
        // (RULE_02) compare C readback
        TCS_OFF_CMP_C: st_d.rdata = {16'h0000, st_q.cmp_c};
        TCS_OFF_STATUS: st_d.rdata = status_word;
        // (RULE_16) mask readback
        TCS_OFF_IRQ_MASK: st_d.rdata = {24'h000000, st_q.mask};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.cmp_b <= TCS_RST_CMP;
      st_q.cmp_c <= TCS_RST_CMP;
      st_q.flags <= TCS_RST_EV;
      st_q.mask <= TCS_RST_MASK;
      st_q.pend_a <= 1'b0;
      st_q.pend_b <= 1'b0;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = st_q.rdata;
  // (RULE_17) masked interrupt
  assign irq = |(st_q.flags & st_q.mask);

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  ovf_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_overflow |=> st_q.flags[TCS_EV_OVF]) // (RULE_03)
    else $error("overflow flag not set");
  status_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == TCS_OFF_STATUS && ev == 8'h00) |=> st_q.flags == 8'h00) // (RULE_18)
    else $error("status read did not clear flags");
  cpa_wave_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wave_mode && !$past(wave_mode) && rd && paddr == TCS_OFF_STATUS)
    |=> !st_q.flags[TCS_EV_CPA]) // (RULE_05)
    else $error("match A flag set in capture mode");
  ld_capt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wave_mode && ev_load_a) |=> st_q.flags[TCS_EV_LDA] == $past(st_q.flags[TCS_EV_LDA])
    || $past(rd)) // (RULE_08)
    else $error("load A flag set in waveform mode");
  lovr_det_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wave_mode && ev_load_a ##1 (!wave_mode && ev_load_a && !read_capture_a))
    |=> st_q.flags[TCS_EV_LOVR]) // (RULE_04)
    else $error("load overrun missed");
  mask_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == TCS_OFF_IRQ_EN && pstrb[0])
    |=> (st_q.mask & $past(pwdata[7:0])) == $past(pwdata[7:0])) // (RULE_14)
    else $error("enable did not set mask");
  mask_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == TCS_OFF_IRQ_DIS && pstrb[0])
    |=> (st_q.mask & $past(pwdata[7:0])) == 8'h00) // (RULE_15)
    else $error("disable did not clear mask");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_17)
    $rose(irq) |-> $past(|(ev & st_q.mask)) || $past(wr && paddr == TCS_OFF_IRQ_EN))
    else $error("interrupt without enabled flag");
  cmpc_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == TCS_OFF_CMP_C && pstrb[1:0] == 2'b11)
    |=> st_q.cmp_c == $past(pwdata[15:0])) // (RULE_02)
    else $error("compare C write lost");
  cmpb_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wave_mode && !ev_load_b) |=> $stable(st_q.cmp_b)) // (RULE_01)
    else $error("compare B changed in capture mode");
  // (RULE_04) second unread B load
  ovr_b_det_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_04)
    (!wave_mode && ev_load_b && st_q.pend_b) |=> st_q.flags[TCS_EV_LOVR])
    else $error("load overrun on B missed");
  // (RULE_04) no overrun in waveform
  lovr_wave_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_04)
    (wave_mode && rd && paddr == TCS_OFF_STATUS) |=> !st_q.flags[TCS_EV_LOVR])
    else $error("overrun flag set in waveform mode");
  // (RULE_06) no match B in capture
  cpb_capt_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_06)
    (!wave_mode && rd && paddr == TCS_OFF_STATUS) |=> !st_q.flags[TCS_EV_CPB])
    else $error("match B flag set in capture mode");
  // (RULE_08) no load A in waveform
  lda_wave_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_08)
    (wave_mode && rd && paddr == TCS_OFF_STATUS) |=> !st_q.flags[TCS_EV_LDA])
    else $error("load A flag after clear in waveform mode");
  // (RULE_09) no load B in waveform
  ldb_wave_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_09)
    (wave_mode && rd && paddr == TCS_OFF_STATUS) |=> !st_q.flags[TCS_EV_LDB])
    else $error("load B flag after clear in waveform mode");
  // (RULE_05) match A latched
  cpa_set_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_05)
    (wave_mode && ev_match_a) |=> st_q.flags[TCS_EV_CPA])
    else $error("match A flag not set");
  // (RULE_06) match B latched
  cpb_set_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_06)
    (wave_mode && ev_match_b) |=> st_q.flags[TCS_EV_CPB])
    else $error("match B flag not set");
  // (RULE_07) match C latched
  cpc_set_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_07)
    ev_match_c |=> st_q.flags[TCS_EV_CPC])
    else $error("match C flag not set");
  // (RULE_08) load A latched
  lda_set_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_08)
    (!wave_mode && ev_load_a) |=> st_q.flags[TCS_EV_LDA])
    else $error("load A flag not set");
  // (RULE_09) load B latched
  ldb_set_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_09)
    (!wave_mode && ev_load_b) |=> st_q.flags[TCS_EV_LDB])
    else $error("load B flag not set");
  // (RULE_10) trigger latched
  etrg_set_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_10)
    ev_ext_trigger |=> st_q.flags[TCS_EV_ETRG])
    else $error("external trigger flag not set");
  // (RULE_03) flags drop only on read
  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_03)
    !(rd && paddr == TCS_OFF_STATUS) |=> (st_q.flags & $past(st_q.flags)) == $past(st_q.flags))
    else $error("event flag lost without status read");
  // (RULE_11) clock state in read data
  clk_live_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_11)
    (psel && !penable && !pwrite && paddr == TCS_OFF_STATUS)
    |=> prdata[TCS_ST_CLK] == $past(counter_clock_on))
    else $error("clock state bit wrong");
  // (RULE_16) mask read data
  mask_read_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_16)
    (psel && !penable && !pwrite && paddr == TCS_OFF_IRQ_MASK)
    |=> prdata == {24'h000000, $past(st_q.mask)})
    else $error("mask readback wrong");
  // (RULE_18) unused status bits zero
  status_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_18)
    (psel && !penable && !pwrite && paddr == TCS_OFF_STATUS)
    |=> prdata[31:19] == 13'h0000 && prdata[15:8] == 8'h00)
    else $error("unused status bits not zero");
  // (RULE_17) enabled event raises request
  irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_17)
    (|(ev & st_q.mask) && !(wr && paddr == TCS_OFF_IRQ_DIS)) |=> irq)
    else $error("interrupt not raised");
  // (RULE_01) compare B write in waveform
  cmpb_wave_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_01)
    (wave_mode && wr && paddr == TCS_OFF_CMP_B && pstrb[1:0] == 2'b11)
    |=> st_q.cmp_b == $past(pwdata[15:0]))
    else $error("compare B write lost");
  // (RULE_02) compare C read data
  cmpc_read_a: assert property (@(posedge pclk) disable iff (!presetn) // (RULE_02)
    (psel && !penable && !pwrite && paddr == TCS_OFF_CMP_C)
    |=> prdata == {16'h0000, $past(st_q.cmp_c)})
    else $error("compare C readback wrong");
endmodule : tcs_top
`default_nettype wire

// ==== tcs_top_bench.sv ====
// Self-checking testbench for the timer channel status block
`timescale 1ns/1ps
`default_nettype none
module tcs_top_bench
  import tcs_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wave_mode = 1'b0;
  logic counter_clock_on = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [15:0] capture_b_data = 16'h0000;
  logic read_capture_a = 1'b0;
  logic [15:0] cmp_b = 16'h0000;
  logic [15:0] cmp_c = 16'h0000;
  logic [3:0] lines = 4'h0;
  logic irq;
  logic [31:0] rd;
  logic er;
  logic [7:0] dm;
  logic [7:0] ex;
  logic [31:0] live;
  logic [31:0] wd;
  logic [3:0] sb;
  int error_cnt = 0;
  int total_checks = 0;

  // Clock at 250 MHz
  always #2 pclk = ~pclk;

  tcs_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wave_mode(wave_mode), .counter_clock_on(counter_clock_on),
    .ev_overflow(ev[0]), .ev_match_a(ev[2]), .ev_match_b(ev[3]), .ev_match_c(ev[4]),
    .ev_ext_trigger(ev[7]), .ev_load_a(ev[5]), .ev_load_b(ev[6]),
    .capture_b_data(capture_b_data), .read_capture_a(read_capture_a),
    .timer_line_a_pin(lines[0]), .timer_line_b_pin(lines[1]),
    .timer_line_a_drv(lines[2]), .timer_line_b_drv(lines[3]), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      error_cnt++;
      $display("[FAIL] pready expected 1 seen timeout");
      wrap_up();
    end
  endtask : apb

  // Event strobes held for n cycles
  task automatic pulse(input logic [7:0] v, input int n);
    @(posedge pclk);
    ev <= v;
    repeat (n) @(posedge pclk);
    ev <= 8'h00;
  endtask : pulse

  // Byte-lane merge of a 16-bit register write
  function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = o;
    if (s[0]) merge16[7:0] = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction : merge16

  // Flags expected from one event kind in a mode
  // a selects the overrun from back-to-back A loads
  function automatic logic [7:0] exp_ev(input int i, input logic w, input logic a);
    case (i)
      1: exp_ev = w ? 8'h00 : (a ? 8'h22 : 8'h42);
      2, 3: exp_ev = w ? (8'h01 << i) : 8'h00;
      5, 6: exp_ev = w ? 8'h00 : (8'h01 << i);
      default: exp_ev = 8'h01 << i;
    endcase
  endfunction : exp_ev

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(43));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    apb(1'b0, TCS_OFF_STATUS, 32'h0, rd, er);
    chk("status reset", 32'h0, rd);
    apb(1'b0, TCS_OFF_IRQ_MASK, 32'h0, rd, er);
    chk("mask reset", 32'h0, rd);
    chk("irq reset", 32'h0, {31'h0, irq});
    apb(1'b0, TCS_OFF_CMP_B, 32'h0, rd, er);
    chk("compare b reset", 32'h0, rd);
    apb(1'b0, TCS_OFF_CMP_C, 32'h0, rd, er);
    chk("compare c reset", 32'h0, rd);
    $display("test reset done");
    // Unmapped offset refused
    apb(1'b1, 8'h18, 32'hffff_ffff, rd, er);
    chk("unmapped write err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h18, 32'h0, rd, er);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped read err", 32'h1, {31'h0, er});
    $display("test unmapped done");
    // Every event kind in both modes, random mask and live levels
    for (int rep = 0; rep < 2; rep++) begin
      for (int w = 0; w < 2; w++) begin
        for (int i = 0; i < 8; i++) begin
          @(posedge pclk);
          wave_mode <= w[0];
          counter_clock_on <= 1'($urandom());
          lines <= 4'($urandom());
          capture_b_data <= 16'($urandom());
          sb = 4'($urandom());
          pstrb <= sb;
          wd = $urandom();
          apb(1'b1, TCS_OFF_CMP_B, wd, rd, er);
          if (w[0]) begin
            cmp_b = merge16(cmp_b, wd, sb);
          end
          apb(1'b0, TCS_OFF_CMP_B, 32'h0, rd, er);
          chk("compare b", {16'h0, cmp_b}, rd);
          wd = $urandom();
          apb(1'b1, TCS_OFF_CMP_C, wd, rd, er);
          cmp_c = merge16(cmp_c, wd, sb);
          apb(1'b0, TCS_OFF_CMP_C, 32'h0, rd, er);
          chk("compare c", {16'h0, cmp_c}, rd);
          pstrb <= 4'hf;
          @(posedge pclk);
          read_capture_a <= 1'b1;
          @(posedge pclk);
          read_capture_a <= 1'b0;
          apb(1'b0, TCS_OFF_STATUS, 32'h0, rd, er);
          dm = 8'($urandom());
          apb(1'b1, TCS_OFF_IRQ_EN, 32'hff, rd, er);
          apb(1'b1, TCS_OFF_IRQ_DIS, {24'h0, dm}, rd, er);
          apb(1'b0, TCS_OFF_IRQ_MASK, 32'h0, rd, er);
          chk("mask", {24'h0, ~dm}, rd);
          chk("mapped err", 32'h0, {31'h0, er});
          ex = exp_ev(i, w[0], rep[0]);
          if (i == 1 && rep == 1) begin
            pulse(8'h20, 2);
          end else if (i == 1) begin
            pulse(8'h40, 1);
            pulse(8'h40, 1);
          end else begin
            pulse(8'h01 << i, 1);
          end
          // Capture loads move compare B
          if (!w[0] && (i == 6 || (i == 1 && rep == 0))) begin
            cmp_b = capture_b_data;
          end
          repeat (2) @(posedge pclk);
          chk("irq set", {31'h0, |(ex & ~dm)}, {31'h0, irq});
          live = 32'h0;
          live[TCS_ST_CLK] = counter_clock_on;
          live[TCS_ST_MIRA] = w[0] ? lines[2] : lines[0];
          live[TCS_ST_MIRB] = w[0] ? lines[3] : lines[1];
          apb(1'b0, TCS_OFF_STATUS, 32'h0, rd, er);
          chk("status", live | {24'h0, ex}, rd);
          // are covered by the line above
          apb(1'b0, TCS_OFF_STATUS, 32'h0, rd, er);
          chk("status cleared", live, rd);
          @(posedge pclk);
          chk("irq cleared", 32'h0, {31'h0, irq});
        end
      end
      $display("test events pass %0d done", rep);
    end
    apb(1'b0, TCS_OFF_CMP_B, 32'h0, rd, er);
    chk("compare b final", {16'h0, cmp_b}, rd);
    wrap_up();
  end
endmodule : tcs_top_bench
`default_nettype wire
